// ---- core/rhbc_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rhbc_params.svh"
// Function
// [R1] Above upper level: high off, dead, low on.
// [R2] Below lower level: low off, dead, high on.
// [R3] Less feedback current widens the level difference.
// [R4] Slowly trim optocurrent to 85 microamps.
// [R5] Soft-start ramp from strapped start difference.
// [R6] High power regulates difference; drops to low power.
// [R7] Low power: low, high, low, hold; boosted.
// [R8] Reduce difference first, then lengthen hold.
// [R9] Cycle not slower than 23 kHz; then burst.
// [R10] Off: low-side on, held minimum on-time.
// [R11] Leave on-state on level, overcurrent, capacitive, timeout.
// [R12] Dead wait minimum, then peak and current.
// [R13] No peak: advance at maximum dead time.
// [R14] High-side states mirror the low-side states.
// [R15] Least energy and duty, 106 microamps: burst.
// [R16] On and dead limits are clock counts.
module rhbc_core
    import rhbc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] sense_pins,
    input wire logic [7:0] feedback_sense,
    input wire logic [7:0] low_side_gate_strap,
    output logic high_side_gate,
    output logic low_side_gate,
    output logic [7:0] cap_upper_level,
    output logic [7:0] cap_lower_level,
    output logic burst_request
);

    logic [21:0] sync_bus;
    rhbc_sense_s sense;
    logic [7:0] fb_ua;
    logic [7:0] strap_code;
    logic enable_q;
    logic [7:0] pt_q;
    rhbc_timing_s tim_q;
    logic [7:0] start_delta_q;
    logic [1:0] strap_cnt_q;
    rhbc_state_e state_q;
    rhbc_state_e state_d;
    logic [15:0] tcnt_q;
    logic [15:0] period_q;
    logic [1:0] half_q;
    logic [7:0] delta;
    rhbc_mode_e mode;
    logic [15:0] hold_cyc;
    logic burst_req;
    logic on_exit;
    logic dead_exit;
    logic hold_exit;
    logic end_level;
    logic apb_setup;
    logic apb_access;

    rhbc_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({sense_pins, feedback_sense, low_side_gate_strap}),
        .sync_out(sync_bus)
    );

    assign sense = rhbc_sense_s'(sync_bus[21:16]);
    assign fb_ua = sync_bus[15:8];
    assign strap_code = sync_bus[7:0];

    rhbc_power_ctl u_power
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(enable_q),
        .fb_ua(fb_ua),
        .start_delta(start_delta_q),
        .pt_level(pt_q),
        .delta_q(delta),
        .mode_q(mode),
        .hold_cyc_q(hold_cyc),
        .burst_req_q(burst_req)
    );

    // The strap is read once the synchroniser has filled after reset release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_cnt_q <= 2'h0;
            start_delta_q <= 8'h00;
        end
        else if (strap_cnt_q != 2'h3)
        begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'h2)
                start_delta_q <= strap_code; // [R5]
        end
    end

    // Exit terms; the high-side states reuse them with the comparator swapped.
    always_comb
    begin
        end_level = (state_q == RHBC_HS_ON) ? sense.above_upper : sense.below_lower; // [R14]
        on_exit = tcnt_q >= tim_q.min_on
            && (end_level || sense.overcurrent || sense.cap_mode_near
            || tcnt_q >= tim_q.max_on || (state_q == RHBC_HS_ON && !enable_q)); // [R11]
        dead_exit = tcnt_q >= tim_q.min_dead && sense.res_current_le0
            && (sense.hb_peak || tcnt_q >= tim_q.max_dead); // [R12] [R13]
        // Hold lasts half the active time, keeping two-thirds duty, plus the extra hold.
        hold_exit = {2'b00, tcnt_q} + {1'b0, tcnt_q, 1'b0}
            >= {2'b00, period_q} + {1'b0, hold_cyc, 1'b0}
            || period_q >= 16'(`RHBC_LP_MAX_PERIOD_CYC); // [R7] [R8] [R9]
    end

    // Next state of the gate sequencer.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RHBC_LS_ON:
                if (enable_q && on_exit)
                    state_d = RHBC_LS_DEAD; // [R2] [R10]
            RHBC_LS_DEAD:
                if (dead_exit)
                    state_d = (mode == RHBC_LOW_POWER && half_q == 2'h3)
                        ? RHBC_HOLD : RHBC_HS_ON; // [R7]
            RHBC_HS_ON:
                if (on_exit)
                    state_d = RHBC_HS_DEAD; // [R1]
            RHBC_HS_DEAD:
                if (dead_exit)
                    state_d = RHBC_LS_ON; // [R1] [R14]
            RHBC_HOLD:
                if (hold_exit || !enable_q)
                    state_d = RHBC_LS_ON; // [R8]
            default:
                state_d = RHBC_LS_ON;
        endcase
    end

    // Sequencer state, state timer and gate drive; gates follow the next state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= RHBC_LS_ON;
            tcnt_q <= 16'h0000;
            low_side_gate <= 1'b1;
            high_side_gate <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tcnt_q <= (state_d != state_q) ? 16'h0000
                : tcnt_q + {15'h0000, tcnt_q != 16'hffff}; // [R16]
            low_side_gate <= state_d == RHBC_LS_ON; // [R10]
            high_side_gate <= state_d == RHBC_HS_ON;
        end
    end

    // Low-power cycle bookkeeping: half-cycles since the last hold and cycle length.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_q <= 2'h0;
            period_q <= 16'h0000;
        end
        else if (state_q == RHBC_HOLD && state_d == RHBC_LS_ON)
        begin
            half_q <= 2'h0;
            period_q <= 16'h0000;
        end
        else
        begin
            if ((state_q == RHBC_LS_ON || state_q == RHBC_HS_ON) && state_d != state_q)
                half_q <= (mode == RHBC_LOW_POWER)
                    ? half_q + {1'b0, half_q != 2'h3} : 2'h0; // [R7]
            period_q <= (mode == RHBC_LOW_POWER && period_q != 16'hffff)
                ? period_q + 16'h0001 : 16'h0000;
        end
    end

    // Levels centred on mid scale; a wider difference means more power.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_upper_level <= `RHBC_CAP_MID;
            cap_lower_level <= `RHBC_CAP_MID;
            burst_request <= 1'b0;
        end
        else
        begin
            cap_upper_level <= `RHBC_CAP_MID + {1'b0, delta[7:1]}; // [R3]
            cap_lower_level <= `RHBC_CAP_MID - {1'b0, delta[7:1]}; // [R3]
            burst_request <= burst_req; // [R9] [R15]
        end
    end

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && pready;

    // Register writes land at the access edge only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= 1'b0;
            pt_q <= `RHBC_PT_RST;
            tim_q.min_on <= 16'(`RHBC_MIN_ON_CYC);
            tim_q.max_on <= 16'(`RHBC_MAX_ON_CYC);
            tim_q.min_dead <= 16'(`RHBC_MIN_DEAD_CYC);
            tim_q.max_dead <= 16'(`RHBC_MAX_DEAD_CYC);
        end
        else if (apb_access && pwrite)
        begin
            case (paddr)
                `RHBC_REG_CTRL: enable_q <= pwdata[0];
                `RHBC_REG_PT: pt_q <= pwdata[7:0]; // [R6]
                `RHBC_REG_MIN_ON: tim_q.min_on <= pwdata[15:0]; // [R16]
                `RHBC_REG_MAX_ON: tim_q.max_on <= pwdata[15:0]; // [R16]
                `RHBC_REG_MIN_DEAD: tim_q.min_dead <= pwdata[15:0]; // [R16]
                `RHBC_REG_MAX_DEAD: tim_q.max_dead <= pwdata[15:0]; // [R16]
                default: enable_q <= enable_q;
            endcase
        end
    end

    // No wait state: the answer is prepared in the setup cycle, so pready is a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (apb_setup)
        begin
            pready <= 1'b1;
            pslverr <= paddr > `RHBC_REG_LEVELS || paddr[1:0] != 2'h0;
            case (paddr)
                `RHBC_REG_CTRL: prdata <= {31'h00000000, enable_q};
                `RHBC_REG_PT: prdata <= {24'h000000, pt_q};
                `RHBC_REG_MIN_ON: prdata <= {16'h0000, tim_q.min_on};
                `RHBC_REG_MAX_ON: prdata <= {16'h0000, tim_q.max_on};
                `RHBC_REG_MIN_DEAD: prdata <= {16'h0000, tim_q.min_dead};
                `RHBC_REG_MAX_DEAD: prdata <= {16'h0000, tim_q.max_dead};
                `RHBC_REG_STATUS: prdata <= {24'h000000, half_q, burst_request, mode, 1'b0, state_q};
                `RHBC_REG_LEVELS: prdata <= {16'h0000, cap_upper_level, cap_lower_level};
                default: prdata <= 32'h00000000;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    chk_no_overlap: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        !(high_side_gate && low_side_gate))
        else $error("Both gates on together.");

    chk_hs_off_above: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        state_q == RHBC_HS_ON && tcnt_q >= tim_q.min_on && sense.above_upper
        |=> !high_side_gate ##1 !low_side_gate)
        else $error("High side not released above the upper level.");

    chk_ls_off_below: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        state_q == RHBC_LS_ON && enable_q && tcnt_q >= tim_q.min_on && sense.below_lower
        |=> !low_side_gate && state_q == RHBC_LS_DEAD)
        else $error("Low side not released below the lower level.");

    chk_off_low_side: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        !enable_q && state_q == RHBC_LS_ON |=> low_side_gate && !high_side_gate)
        else $error("Low side not held while the converter is off.");

    chk_min_on: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        $fell(low_side_gate) |-> $past(tcnt_q) >= $past(tim_q.min_on))
        else $error("Low side released before the minimum on-time.");

    chk_max_on: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        state_q == RHBC_HS_ON && tcnt_q >= tim_q.max_on && tcnt_q >= tim_q.min_on
        |=> state_q == RHBC_HS_DEAD)
        else $error("High side held beyond the maximum on-time.");

    chk_min_dead: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        $rose(high_side_gate) |-> $past(tcnt_q) >= $past(tim_q.min_dead)
        && $past(sense.res_current_le0))
        else $error("High side turned on inside the minimum dead time.");

    chk_max_dead: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        state_q == RHBC_HS_DEAD && tcnt_q >= tim_q.max_dead && tcnt_q >= tim_q.min_dead
        && sense.res_current_le0 |=> low_side_gate)
        else $error("Dead time not ended at its maximum.");

    chk_lp_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        $rose(state_q == RHBC_HOLD) |-> $past(state_q) == RHBC_LS_DEAD && $past(half_q) == 2'h3
        && $past(mode) == RHBC_LOW_POWER)
        else $error("Hold entered outside the low-power sequence.");

    chk_lp_period: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        state_q == RHBC_HOLD && period_q >= 16'(`RHBC_LP_MAX_PERIOD_CYC)
        |=> state_q == RHBC_LS_ON)
        else $error("Low-power cycle exceeded its longest period.");

    cov_hold: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == RHBC_HOLD ##1 state_q == RHBC_LS_ON);
    cov_full_cycle: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(high_side_gate) ##[1:1000] $rose(low_side_gate));
    cov_burst: cover property (@(posedge pclk) disable iff (!presetn) $rose(burst_request));

endmodule
`default_nettype wire

// ---- core/rhbc_params.svh ----
`ifndef RHBC_PARAMS_SVH
`define RHBC_PARAMS_SVH

// Controller clock and derived timing.
`define RHBC_CLK_HZ 40000000
`define RHBC_CLK_NS 25
`define RHBC_LP_MIN_FREQ_HZ 23000
`define RHBC_LP_MAX_PERIOD_CYC (`RHBC_CLK_HZ / `RHBC_LP_MIN_FREQ_HZ)
`define RHBC_MIN_ON_NS 1000
`define RHBC_MAX_ON_NS 25000
`define RHBC_MIN_DEAD_NS 100
`define RHBC_MAX_DEAD_NS 1000
`define RHBC_TRIM_NS 100000
`define RHBC_RAMP_NS 10000
`define RHBC_MIN_ON_CYC ((`RHBC_MIN_ON_NS + `RHBC_CLK_NS - 1) / `RHBC_CLK_NS)
`define RHBC_MAX_ON_CYC (`RHBC_MAX_ON_NS / `RHBC_CLK_NS)
`define RHBC_MIN_DEAD_CYC ((`RHBC_MIN_DEAD_NS + `RHBC_CLK_NS - 1) / `RHBC_CLK_NS)
`define RHBC_MAX_DEAD_CYC (`RHBC_MAX_DEAD_NS / `RHBC_CLK_NS)
`define RHBC_TRIM_CYC (`RHBC_TRIM_NS / `RHBC_CLK_NS)
`define RHBC_RAMP_CYC (`RHBC_RAMP_NS / `RHBC_CLK_NS)

// Optocoupler current levels in microamps.
`define RHBC_FB_TARGET_UA 8'h55
`define RHBC_FB_BURST_UA 8'h6a

// Capacitor level codes and hold step.
`define RHBC_CAP_MID 8'h80
`define RHBC_DELTA_MIN 8'h10
`define RHBC_MODE_HYS 8'h08
`define RHBC_HOLD_STEP 16'h0080
`define RHBC_PT_RST 8'h30

// Register byte offsets.
`define RHBC_REG_CTRL 8'h00
`define RHBC_REG_PT 8'h04
`define RHBC_REG_MIN_ON 8'h08
`define RHBC_REG_MAX_ON 8'h0c
`define RHBC_REG_MIN_DEAD 8'h10
`define RHBC_REG_MAX_DEAD 8'h14
`define RHBC_REG_STATUS 8'h18
`define RHBC_REG_LEVELS 8'h1c

// Synchroniser width: six comparator bits, feedback code, strap code.
`define RHBC_SYNC_W 22

`endif

// ---- core/rhbc_pkg.sv ----
package rhbc_pkg;

    typedef enum logic [2:0]
    {
        RHBC_LS_ON = 3'b000,
        RHBC_LS_DEAD = 3'b001,
        RHBC_HS_ON = 3'b010,
        RHBC_HS_DEAD = 3'b011,
        RHBC_HOLD = 3'b100
    } rhbc_state_e;

    typedef enum logic
    {
        RHBC_HIGH_POWER = 1'b0,
        RHBC_LOW_POWER = 1'b1
    } rhbc_mode_e;

    // Comparator events from the power stage.
    typedef struct packed
    {
        logic above_upper;
        logic below_lower;
        logic overcurrent;
        logic cap_mode_near;
        logic hb_peak;
        logic res_current_le0;
    } rhbc_sense_s;

    // Timing counts held in software registers.
    typedef struct packed
    {
        logic [15:0] min_on;
        logic [15:0] max_on;
        logic [15:0] min_dead;
        logic [15:0] max_dead;
    } rhbc_timing_s;

endpackage

// ---- core/rhbc_power_ctl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rhbc_params.svh"
module rhbc_power_ctl
    import rhbc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] fb_ua,
    input wire logic [7:0] start_delta,
    input wire logic [7:0] pt_level,
    output logic [7:0] delta_q,
    output rhbc_mode_e mode_q,
    output logic [15:0] hold_cyc_q,
    output logic burst_req_q
);

    localparam logic [15:0] TrimCyc = 16'(`RHBC_TRIM_CYC);
    localparam logic [15:0] RampCyc = 16'(`RHBC_RAMP_CYC);
    localparam logic [15:0] HoldMax = 16'(`RHBC_LP_MAX_PERIOD_CYC);

    // Clamp a signed sum to an unsigned 8-bit code.
    function automatic logic [7:0] rhbc_sat8(input logic signed [10:0] v);
        if (v < 11'sd0)
            return 8'h00;
        else if (v > 11'sd255)
            return 8'hff;
        else
            return v[7:0];
    endfunction

    logic signed [8:0] offset_q;
    logic [15:0] trim_cnt_q;
    logic [15:0] ramp_cnt_q;
    logic [7:0] ramp_q;
    logic [7:0] demand;
    logic [7:0] lp_delta;
    logic [8:0] lp_raw;
    logic [15:0] hold_d;

    // Less feedback current means more demanded power; the trim offset is added on top.
    always_comb
    begin
        demand = rhbc_sat8(11'sd255 - $signed({3'b000, fb_ua}) + 11'(offset_q)); // [R3]
        lp_raw = {1'b0, demand} + {2'b00, demand[7:1]}; // [R7]
        lp_delta = rhbc_sat8($signed({2'b00, lp_raw}));
        hold_d = 16'h0000;
        if (lp_raw < {1'b0, `RHBC_DELTA_MIN})
        begin
            // Below the least energy per cycle, the hold time takes over.
            hold_d = 16'(`RHBC_DELTA_MIN - lp_raw[7:0]) * `RHBC_HOLD_STEP; // [R8]
            lp_delta = `RHBC_DELTA_MIN;
        end
        if (hold_d > HoldMax)
            hold_d = HoldMax; // [R9]
    end

    // Slow optocurrent trim; it is frozen while stopped so a restart keeps its state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            offset_q <= 9'sh000;
            trim_cnt_q <= 16'h0000;
        end
        else if (run)
        begin
            trim_cnt_q <= (trim_cnt_q >= TrimCyc - 16'h0001) ? 16'h0000 : trim_cnt_q + 16'h0001;
            if (trim_cnt_q == 16'h0000)
            begin
                if (fb_ua < `RHBC_FB_TARGET_UA && offset_q < 9'sd255)
                    offset_q <= offset_q + 9'sd1; // [R4]
                else if (fb_ua > `RHBC_FB_TARGET_UA && offset_q > -9'sd255)
                    offset_q <= offset_q - 9'sd1; // [R4]
            end
        end
    end

    // Soft start ramp of the level difference from the strapped start value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_q <= 8'h00;
            ramp_cnt_q <= 16'h0000;
        end
        else if (!run)
        begin
            ramp_q <= start_delta; // [R5]
            ramp_cnt_q <= 16'h0000;
        end
        else
        begin
            ramp_cnt_q <= (ramp_cnt_q >= RampCyc - 16'h0001) ? 16'h0000 : ramp_cnt_q + 16'h0001;
            if (ramp_cnt_q == 16'h0000 && ramp_q != 8'hff)
                ramp_q <= ramp_q + 8'h01; // [R5]
        end
    end

    // Mode choice with hysteresis, and the resulting level difference.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= RHBC_HIGH_POWER;
            delta_q <= 8'h00;
            hold_cyc_q <= 16'h0000;
            burst_req_q <= 1'b0;
        end
        else
        begin
            if (!run)
                mode_q <= RHBC_HIGH_POWER;
            else if (mode_q == RHBC_HIGH_POWER && demand < pt_level)
                mode_q <= RHBC_LOW_POWER; // [R6]
            else if (mode_q == RHBC_LOW_POWER
                && {1'b0, demand} >= {1'b0, pt_level} + 9'(`RHBC_MODE_HYS))
                mode_q <= RHBC_HIGH_POWER;
            if (mode_q == RHBC_HIGH_POWER)
            begin
                delta_q <= (demand < ramp_q) ? demand : ramp_q; // [R6]
                hold_cyc_q <= 16'h0000;
            end
            else
            begin
                delta_q <= (lp_delta < ramp_q) ? lp_delta : ramp_q; // [R7]
                hold_cyc_q <= hold_d; // [R8]
            end
            burst_req_q <= run && mode_q == RHBC_LOW_POWER && hold_d == HoldMax
                && fb_ua > `RHBC_FB_BURST_UA; // [R15]
        end
    end

    chk_trim_bounded: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        offset_q != $past(offset_q) |-> $past(trim_cnt_q) == 16'h0000)
        else $error("Trim offset moved outside its slow step.");

    chk_lp_entry: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        run && mode_q == RHBC_HIGH_POWER && demand < pt_level |=> mode_q == RHBC_LOW_POWER)
        else $error("Low-power mode not entered below the transition level.");

endmodule
`default_nettype wire

// ---- core/rhbc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module rhbc_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [21:0] async_in,
    output logic [21:0] sync_out
);

    logic [21:0] meta_q;

    // Two stages; only the second stage is seen by the logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 22'h000000;
            sync_out <= 22'h000000;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/rhbc_far_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module rhbc_far_end
    import rhbc_pkg::*;
#(
    parameter int RES_CYC = 60,
    parameter int PEAK_CYC = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic res_le0,
    input wire logic peak_en,
    output logic [5:0] sense_pins
);
    logic [1:0] gates_q;
    logic [15:0] cnt_q;
    rhbc_sense_s s;

    // Phase timer restarts whenever the gate pattern changes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gates_q <= 2'b01;
            cnt_q <= 16'h0000;
        end
        else
        begin
            gates_q <= {high_side_gate, low_side_gate};
            cnt_q <= (gates_q == {high_side_gate, low_side_gate}) ? cnt_q + 16'h0001 : 16'h0000;
        end
    end

    // The tank swings a fixed time into each phase; a peak shows only while both are off.
    always_comb
    begin
        s = '0;
        s.above_upper = gates_q == 2'b10 && cnt_q >= RES_CYC;
        s.below_lower = gates_q == 2'b01 && cnt_q >= RES_CYC;
        s.hb_peak = gates_q == 2'b00 && cnt_q >= PEAK_CYC && peak_en;
        s.res_current_le0 = res_le0;
        sense_pins = s;
    end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rhbc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, fb = 8'h80, up, lo;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, hsg, lsg, burst, res_le0 = 1'b1, peak_en = 1'b1;
    logic [5:0] sense;
    int mismatches = 0, checks = 0, cycles = 0;

    rhbc_core rhbc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_pins(sense), .feedback_sense(fb),
        .low_side_gate_strap(8'h10), .high_side_gate(hsg), .low_side_gate(lsg),
        .cap_upper_level(up), .cap_lower_level(lo), .burst_request(burst));
    rhbc_far_end rhbc_far_end_i (.pclk(pclk), .presetn(presetn), .high_side_gate(hsg),
        .low_side_gate(lsg), .res_le0(res_le0), .peak_en(peak_en), .sense_pins(sense));

    always #12.5 pclk = ~pclk;

    // A hang ends the run through the same closing report.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] d;
        logic err;
        apb(1'b0, a, 32'h0, d, err);
        check($sformatf("reg %h data", a), exp, d);
        check($sformatf("reg %h error", a), {31'h0, e}, {31'h0, err});
    endtask

    // Counts edges until the gate pair shows the wanted pattern {high, low}.
    task automatic wait_pat(input logic [1:0] pat, output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ({hsg, lsg} !== pat && n < 3000);
        check("gate pattern", {30'h0, pat}, {30'h0, hsg, lsg});
    endtask

    task automatic t_regs();
        logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
        logic [31:0] v [7] = '{32'h0, 32'h30, 32'h28, 32'h3e8, 32'h4, 32'h28, 32'h0};
        foreach (a[i])
            expect_reg(a[i], v[i], 1'b0);
        expect_reg(8'h20, 32'h0, 1'b1);
        expect_reg(8'h02, 32'h0, 1'b1);
    endtask

    // While off, the low side stays on even as the tank keeps signalling.
    task automatic t_off();
        repeat (200) @(posedge pclk);
        check("off gates", 32'h1, {30'h0, hsg, lsg});
        check("start levels", 32'h8878, {16'h0, up, lo});
    endtask

    task automatic t_switch();
        logic [31:0] d;
        logic err;
        int n;
        apb(1'b1, 8'h00, 32'h1, d, err);
        wait_pat(2'b00, n);
        wait_pat(2'b10, n);
        check("dead after low", 32'h1, {31'h0, n >= 4});
        wait_pat(2'b00, n);
        check("high on time", 32'h1, {31'h0, n >= 40});
        wait_pat(2'b01, n);
    endtask

    // Without a peak the dead time runs to its maximum; negative current is still required.
    task automatic t_maxdead();
        int n;
        peak_en <= 1'b0;
        wait_pat(2'b00, n);
        wait_pat(2'b10, n);
        check("max dead", 32'h1, {31'h0, n >= 40 && n <= 46});
        res_le0 <= 1'b0;
        wait_pat(2'b00, n);
        repeat (100) @(posedge pclk);
        check("dead held", 32'h0, {30'h0, hsg, lsg});
        res_le0 <= 1'b1;
        wait_pat(2'b01, n);
    endtask

    // A zero transition level keeps high power, so the feedback, capped by the soft-start ramp, sets the difference.
    task automatic t_levels();
        logic [31:0] d;
        logic err;
        logic [7:0] u1, l1;
        apb(1'b1, 8'h04, 32'h0, d, err);
        expect_reg(8'h04, 32'h0, 1'b0);
        fb <= 8'hf8;
        repeat (50) @(posedge pclk);
        u1 = up;
        l1 = lo;
        fb <= 8'h20;
        repeat (50) @(posedge pclk);
        check("upper raised", 32'h1, {31'h0, up > u1});
        check("lower dropped", 32'h1, {31'h0, lo < l1});
    endtask

    // Near-zero demand: low power with a long hold, bounded cycle, and the burst hand-off.
    task automatic t_burst();
        logic [31:0] d;
        logic err;
        int run_len, longest;
        run_len = 0;
        longest = 0;
        apb(1'b1, 8'h04, 32'h30, d, err);
        fb <= 8'hff;
        repeat (20) @(posedge pclk);
        check("burst request", 32'h1, {31'h0, burst});
        repeat (3500)
        begin
            @(posedge pclk);
            run_len = (hsg || lsg) ? 0 : run_len + 1;
            longest = (run_len > longest) ? run_len : longest;
        end
        check("hold length", 32'h1, {31'h0, longest > 100 && longest < 1739});
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        check("reset gates", 32'h1, {30'h0, hsg, lsg});
        check("reset levels", 32'h8080, {16'h0, up, lo});
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_off();
        t_switch();
        t_maxdead();
        t_levels();
        t_burst();
        end_of_test();
    end
endmodule
`default_nettype wire
